// ### rtl/iosl_top.sv
// Sampling, sample forwarding and line-passing logic of the radio module.
// How it works
// - Pull direction bits use the same line mapping as pull enables; all ones.
// - With forwarding on, every received sample packet goes out as a frame.
// - Samples per packet 1..0xFF, clamped to payload capacity, read back.
// - Transparent forced sample returns ASCII hex lines ended by CR.
// - Framed forced sample answers OK first, then a sample frame.
// - Output level writes change only lines set up as outputs.
// - Masked digital line changes send a packet with digital data only.
// - Queued samples are sent before the change packet.
// - Nonzero interval in ms, minimum 0x32, samples enabled lines periodically.
// - RSSI output duty follows each packet and stops when its timer ends.
// - RSSI hold value 0xFF keeps that output on forever.
// - Bound address all 0xFF turns line passing off.
// - Bound address 0xFFFF accepts any sample packet for the outputs.
// - Passed line values hold for the line timeout, then revert; 0 holds.
// - Passed duty values hold for the PWM timeout, then revert; 0 holds.
// - Remote analog channel 0 samples set the modulated duty when bound.
// - Modulated period 64 us, 10-bit duty, 0x3FF is full on.
// - Pull mask bits map to lines 4,3,2,1,0,6, sleep and serial input.
`timescale 1ns/1ps
module iosl_top #(
   parameter int MS_CYCLES = iosl_pkg::MS_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cfg_we_i,
   input wire logic cfg_re_i,
   input wire logic [4:0] cfg_id_i,
   input wire logic [63:0] cfg_wdata_i,
   output logic [63:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   input wire logic [7:0] max_spp_i,
   input wire logic [1:0] frame_mode_select_i,
   input wire logic [15:0] chan_enable_i,
   input wire logic [7:0] out_dir_i,
   input wire logic [1:0] first_modulated_config_i,
   input wire logic [1:0] second_modulated_config_i,
   input wire logic [9:0] first_duty_setting_i,
   input wire logic [9:0] second_duty_setting_i,
   input wire logic [7:0] dio_i,
   input wire logic [39:0] adc_i,
   input wire logic force_sample_command_i,
   input wire logic rx_valid_i,
   input wire logic [63:0] rx_src_i,
   input wire logic [7:0] rx_dmask_i,
   input wire logic [7:0] rx_dio_i,
   input wire logic rx_adc0_valid_i,
   input wire logic [9:0] rx_adc0_i,
   input wire logic [9:0] rx_rssi_i,
   input wire logic host_ready_i,
   output logic [7:0] host_byte_o,
   output logic host_valid_o,
   output logic host_frame_o,
   output logic [1:0] host_kind_o,
   output logic fwd_frame_o,
   output logic sample_take_o,
   output logic tx_send_o,
   output logic [7:0] tx_count_o,
   output logic tx_dio_only_o,
   output logic [7:0] tx_dio_o,
   output logic [7:0] dio_out_o,
   output logic [7:0] dio_oe_o,
   output logic first_modulated_output_o,
   output logic second_modulated_output_o,
   output logic [7:0] pull_en_o,
   output logic [7:0] pull_up_o
);
   typedef struct packed {
      iosl_pkg::iosl_st_t st;
      logic [7:0] s1, s2, s3, dst, dref;
      logic [15:0] ms;
      logic [6:0] hund;
      logic [15:0] ivc;
      logic [7:0] qcnt;
      logic [7:0] pdir, pena, spp, lvl, rsh, pwmh;
      logic fwd_en;
      logic [15:0] chgm, ival;
      logic [63:0] baddr;
      logic [7:0][7:0] tmo, tcnt;
      logic [7:0] pass, held;
      logic [9:0] duty0, duty1, rsd;
      logic h0, h1, rson;
      logic [7:0] c0, c1, rsc;
      logic [11:0] ph;
      logic [2:0] fld, dig;
      logic [15:0] smask;
      logic [7:0] sdio;
      logic [39:0] sadc;
      logic [7:0] byt;
      logic bv, hf, fwd, smp, tx, txd;
      logic [1:0] hk;
      logic [7:0] txc, txdio, dout, doe, pen, pup;
      logic pw0, pw1;
      logic [63:0] rd;
      logic rv;
   } iosl_state_t;

   iosl_state_t q, n;
   logic tick, t100, acc, chg, per, tsel;
   logic [2:0] tix, nd, nf;
   logic [15:0] v16;
   logic [3:0] nib;
   logic [9:0] e0, e1;
   logic [7:0] w8;
   logic [15:0] w16;

   // Next field of the text answer after f; disabled fields are skipped.
   function automatic logic [2:0] iosl_next(input logic [2:0] f,
                                            input logic [15:0] m);
      logic [2:0] r;
      r = iosl_pkg::FLD_END;
      for (int k = 6; k >= 1; k--) begin
         if (k > int'(f)) begin
            if (k == 1 || (k == 2 && |m[7:0]) || (k > 2 && m[k + 5])) begin
               r = 3'(k);
            end
         end
      end
      return r;
   endfunction : iosl_next

   always_comb begin
      n = q;
      w8 = cfg_wdata_i[7:0];
      w16 = cfg_wdata_i[15:0];
      tsel = (cfg_id_i >= iosl_pkg::ID_LINE_HOLD0) &&
             (cfg_id_i <= iosl_pkg::ID_LINE_HOLD7);
      tix = 3'(cfg_id_i - iosl_pkg::ID_LINE_HOLD0);
      tick = (q.ms == 16'(MS_CYCLES - 1));
      t100 = tick && (q.hund == iosl_pkg::TICKS_100MS - 7'h01);
      acc = rx_valid_i && (q.baddr != iosl_pkg::ADDR_OFF) &&
            ((q.baddr == iosl_pkg::ADDR_ANY) || (q.baddr == rx_src_i));
      chg = |((q.dst ^ q.dref) & q.chgm[7:0]);
      per = tick && (q.ival != '0) && (|chan_enable_i) &&
            (q.ivc + 16'h0001 >= q.ival);
      nd = (q.fld == iosl_pkg::FLD_COUNT) ? 3'h2 :
           (q.fld == iosl_pkg::FLD_END) ? 3'h0 : 3'h4;
      nf = iosl_next(q.fld, q.smask);
      unique case (q.fld)
         3'h0: v16 = {8'h00, iosl_pkg::SPP_MIN};
         3'h1: v16 = q.smask;
         3'h2: v16 = {8'h00, q.sdio};
         default: v16 = {6'h00, q.sadc[iosl_pkg::ADC_W *
                         (q.fld - iosl_pkg::FLD_ADC0) +: iosl_pkg::ADC_W]};
      endcase
      nib = 4'(v16 >> {(nd - q.dig - 3'h1), 2'b00});
      n.smp = 1'b0;
      n.tx = 1'b0;
      n.hf = 1'b0;
      n.rv = 1'b0;
      n.fwd = rx_valid_i && q.fwd_en;
      // Three flops; a change counts only once the last two agree.
      n.s1 = dio_i;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.dst = (q.dst & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
      // Unmonitored lines track the pins, so enabling one later sees no edge.
      n.dref = (q.dref & q.chgm[7:0]) | (q.dst & ~q.chgm[7:0]);
      n.ms = tick ? '0 : q.ms + 16'h0001;
      if (tick) begin
         n.hund = t100 ? '0 : q.hund + 7'h01;
      end
      if (q.ival == '0 || chan_enable_i == '0) begin
         n.ivc = '0;
      end else if (tick) begin
         n.ivc = per ? '0 : q.ivc + 16'h0001;
      end

      if (cfg_we_i) begin
         case (cfg_id_i)
            iosl_pkg::ID_PULL_DIR: n.pdir = w8;
            iosl_pkg::ID_PULL_EN: n.pena = w8;
            iosl_pkg::ID_FWD_EN: n.fwd_en = w8[0];
            iosl_pkg::ID_SPP: n.spp = (w8 < iosl_pkg::SPP_MIN) ?
               iosl_pkg::SPP_MIN : (w8 > max_spp_i) ? max_spp_i : w8;
            iosl_pkg::ID_OUT_LVL: n.lvl = (q.lvl & ~out_dir_i) |
                                          (w8 & out_dir_i);
            iosl_pkg::ID_CHG_MASK: n.chgm = w16;
            iosl_pkg::ID_INTERVAL: n.ival = (w16 != '0 &&
               w16 < iosl_pkg::IVL_MIN) ? iosl_pkg::IVL_MIN : w16;
            iosl_pkg::ID_RSSI_HOLD: n.rsh = w8;
            iosl_pkg::ID_BOUND_ADDR: n.baddr = cfg_wdata_i;
            iosl_pkg::ID_PWM_HOLD: n.pwmh = w8;
            default: begin
               if (tsel) begin
                  n.tmo[tix] = w8;
               end
            end
         endcase
      end
      if (cfg_re_i) begin
         n.rv = 1'b1;
         n.rd = '0;
         case (cfg_id_i)
            iosl_pkg::ID_PULL_DIR: n.rd[7:0] = q.pdir;
            iosl_pkg::ID_PULL_EN: n.rd[7:0] = q.pena;
            iosl_pkg::ID_FWD_EN: n.rd[0] = q.fwd_en;
            iosl_pkg::ID_SPP: n.rd[7:0] = q.spp;
            iosl_pkg::ID_CHG_MASK: n.rd[15:0] = q.chgm;
            iosl_pkg::ID_INTERVAL: n.rd[15:0] = q.ival;
            iosl_pkg::ID_RSSI_HOLD: n.rd[7:0] = q.rsh;
            iosl_pkg::ID_BOUND_ADDR: n.rd = q.baddr;
            iosl_pkg::ID_PWM_HOLD: n.rd[7:0] = q.pwmh;
            default: begin
               if (tsel) begin
                  n.rd[7:0] = q.tmo[tix];
               end
            end
         endcase
      end

      if (host_ready_i) begin
         n.bv = 1'b0;
      end
      unique case (q.st)
         iosl_pkg::ST_IDLE: begin
            if (chg) begin
               n.dref = q.dst;
               n.txdio = q.dst;
               n.tx = 1'b1;
               if (q.qcnt != '0) begin
                  n.txc = q.qcnt;
                  n.txd = 1'b0;
                  n.qcnt = '0;
                  n.st = iosl_pkg::ST_CHG;
               end else begin
                  n.txc = iosl_pkg::SPP_MIN;
                  n.txd = 1'b1;
               end
            end else if (force_sample_command_i) begin
               n.smask = chan_enable_i;
               n.sdio = q.dst;
               n.sadc = adc_i;
               if (frame_mode_select_i == iosl_pkg::FM_TRANSPARENT) begin
                  n.st = iosl_pkg::ST_TXT;
                  n.fld = iosl_pkg::FLD_COUNT;
                  n.dig = '0;
               end else begin
                  n.hf = 1'b1;
                  n.hk = iosl_pkg::HK_OK;
                  n.st = iosl_pkg::ST_OK;
               end
            end else if (per) begin
               n.smp = 1'b1;
               n.txdio = q.dst;
               if (q.qcnt + 8'h01 >= q.spp) begin
                  n.tx = 1'b1;
                  n.txc = q.qcnt + 8'h01;
                  n.txd = 1'b0;
                  n.qcnt = '0;
               end else begin
                  n.qcnt = q.qcnt + 8'h01;
               end
            end
         end
         iosl_pkg::ST_CHG: begin
            n.tx = 1'b1;
            n.txc = iosl_pkg::SPP_MIN;
            n.txd = 1'b1;
            n.st = iosl_pkg::ST_IDLE;
         end
         iosl_pkg::ST_OK: begin
            n.hf = 1'b1;
            n.hk = iosl_pkg::HK_SAMPLE;
            n.st = iosl_pkg::ST_IDLE;
         end
         iosl_pkg::ST_TXT: begin
            if (!q.bv || host_ready_i) begin
               n.bv = 1'b1;
               if (q.dig < nd) begin
                  n.byt = (nib < 4'hA) ? iosl_pkg::ASC_0 + {4'h0, nib} :
                          iosl_pkg::ASC_A + {4'h0, nib - 4'hA};
                  n.dig = q.dig + 3'h1;
               end else begin
                  n.byt = iosl_pkg::ASC_CR;
                  n.dig = '0;
                  n.fld = nf;
                  if (q.fld == iosl_pkg::FLD_END) begin
                     n.st = iosl_pkg::ST_IDLE;
                  end
               end
            end
         end
      endcase

      for (int i = 0; i < 8; i++) begin
         if (acc && rx_dmask_i[i] && out_dir_i[i]) begin
            n.pass[i] = rx_dio_i[i];
            n.held[i] = 1'b1;
            n.tcnt[i] = q.tmo[i];
         end else if (t100 && q.held[i] && q.tmo[i] != '0) begin
            if (q.tcnt[i] <= 8'h01) begin
               n.held[i] = 1'b0;
            end else begin
               n.tcnt[i] = q.tcnt[i] - 8'h01;
            end
         end
         if (!out_dir_i[i]) begin
            n.held[i] = 1'b0;
         end
         n.pen[i] = q.pena[iosl_pkg::PULL_SRC[i]];
         n.pup[i] = q.pdir[iosl_pkg::PULL_SRC[i]];
      end
      n.dout = ((q.held & q.pass) | (~q.held & q.lvl)) & out_dir_i;
      n.doe = out_dir_i;

      if (acc && rx_adc0_valid_i &&
          first_modulated_config_i == iosl_pkg::PCFG_PWM) begin
         n.duty0 = rx_adc0_i;
         n.h0 = 1'b1;
         n.c0 = q.pwmh;
      end else if (t100 && q.h0 && q.pwmh != '0) begin
         if (q.c0 <= 8'h01) begin
            n.h0 = 1'b0;
         end else begin
            n.c0 = q.c0 - 8'h01;
         end
      end
      if (first_modulated_config_i != iosl_pkg::PCFG_PWM) begin
         n.h0 = 1'b0;
      end
      if (acc && rx_adc0_valid_i &&
          second_modulated_config_i == iosl_pkg::PCFG_PWM) begin
         n.duty1 = rx_adc0_i;
         n.h1 = 1'b1;
         n.c1 = q.pwmh;
      end else if (t100 && q.h1 && q.pwmh != '0) begin
         if (q.c1 <= 8'h01) begin
            n.h1 = 1'b0;
         end else begin
            n.c1 = q.c1 - 8'h01;
         end
      end
      if (second_modulated_config_i != iosl_pkg::PCFG_PWM) begin
         n.h1 = 1'b0;
      end
      if (rx_valid_i && first_modulated_config_i == iosl_pkg::PCFG_RSSI) begin
         n.rsd = rx_rssi_i;
         n.rson = 1'b1;
         n.rsc = q.rsh;
      end else if (t100 && q.rson && q.rsh != iosl_pkg::HOLD_FOREVER) begin
         if (q.rsc <= 8'h01) begin
            n.rson = 1'b0;
         end else begin
            n.rsc = q.rsc - 8'h01;
         end
      end

      e0 = '0;
      if (first_modulated_config_i == iosl_pkg::PCFG_RSSI && q.rson) begin
         e0 = q.rsd;
      end
      if (first_modulated_config_i == iosl_pkg::PCFG_PWM) begin
         e0 = q.h0 ? q.duty0 : first_duty_setting_i;
      end
      e1 = (second_modulated_config_i != iosl_pkg::PCFG_PWM) ? '0 :
           q.h1 ? q.duty1 : second_duty_setting_i;
      // Comparing scaled values avoids a fractional step per duty count.
      n.ph = (q.ph == 12'(iosl_pkg::PWM_CYC - 1)) ? '0 : q.ph + 12'h001;
      n.pw0 = ({10'h000, q.ph} * iosl_pkg::DUTY_FULL) <
              ({12'h000, e0} * 22'(iosl_pkg::PWM_CYC));
      n.pw1 = ({10'h000, q.ph} * iosl_pkg::DUTY_FULL) <
              ({12'h000, e1} * 22'(iosl_pkg::PWM_CYC));

      if (reset_i) begin
         n = '0;
         n.st = iosl_pkg::ST_IDLE;
         n.pdir = iosl_pkg::PULL_DIR_RST;
         n.pena = iosl_pkg::PULL_EN_RST;
         n.fwd_en = iosl_pkg::FWD_EN_RST;
         n.spp = iosl_pkg::SPP_RST;
         n.chgm = iosl_pkg::CHG_MASK_RST;
         n.ival = iosl_pkg::INTERVAL_RST;
         n.rsh = iosl_pkg::RSSI_HOLD_RST;
         n.baddr = iosl_pkg::ADDR_OFF;
         n.pwmh = iosl_pkg::PWM_HOLD_RST;
         n.pen = iosl_pkg::PULL_EN_RST;
         n.pup = iosl_pkg::PULL_DIR_RST;
         for (int i = 0; i < 8; i++) begin
            n.tmo[i] = iosl_pkg::LINE_HOLD_RST;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      q <= n;
   end

   assign cfg_rdata_o = q.rd;
   assign cfg_rvalid_o = q.rv;
   assign host_byte_o = q.byt;
   assign host_valid_o = q.bv;
   assign host_frame_o = q.hf;
   assign host_kind_o = q.hk;
   assign fwd_frame_o = q.fwd;
   assign sample_take_o = q.smp;
   assign tx_send_o = q.tx;
   assign tx_count_o = q.txc;
   assign tx_dio_only_o = q.txd;
   assign tx_dio_o = q.txdio;
   assign dio_out_o = q.dout;
   assign dio_oe_o = q.doe;
   assign first_modulated_output_o = q.pw0;
   assign second_modulated_output_o = q.pw1;
   assign pull_en_o = q.pen;
   assign pull_up_o = q.pup;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_ok_then_data;
      q.hf && q.hk == iosl_pkg::HK_OK ##1 q.hf && q.hk == iosl_pkg::HK_SAMPLE;
   endsequence
   sequence s_queue_then_chg;
      q.tx && !q.txd ##1 q.tx && q.txd && q.txc == iosl_pkg::SPP_MIN;
   endsequence

   a_pull_dir_map: assert property (##2 q.pup[4] == $past(q.pdir[0]) &&
      q.pup[0] == $past(q.pdir[4])) else $error("pull direction map wrong");
   a_fwd_any_mode: assert property (rx_valid_i && q.fwd_en |=> q.fwd)
      else $error("received sample not forwarded");
   a_spp_clamp: assert property (cfg_we_i && cfg_id_i == iosl_pkg::ID_SPP
      |=> q.spp <= $past(max_spp_i) || q.spp == iosl_pkg::SPP_MIN)
      else $error("samples per packet not clamped");
   a_force_text: assert property (q.st == iosl_pkg::ST_IDLE && !chg &&
      force_sample_command_i && frame_mode_select_i == 2'h0
      |=> q.st == iosl_pkg::ST_TXT) else $error("text answer not started");
   a_force_ok_first: assert property (q.st == iosl_pkg::ST_IDLE && !chg &&
      force_sample_command_i && frame_mode_select_i != 2'h0 |=> s_ok_then_data)
      else $error("framed forced sample out of order");
   a_lvl_outputs_only: assert property (##1
      (q.dout & ~$past(out_dir_i)) == '0) else $error("non-output line driven");
   a_queued_first: assert property (q.st == iosl_pkg::ST_IDLE && chg &&
      q.qcnt != '0 |=> s_queue_then_chg) else $error("queue not sent first");
   a_interval_min: assert property (q.ival == '0 ||
      q.ival >= iosl_pkg::IVL_MIN) else $error("interval below minimum");
   a_rssi_forever: assert property (q.rson && q.rsh == 8'hFF
      && !cfg_we_i |=> q.rson) else $error("rssi output expired");
   a_pass_off: assert property (q.baddr == iosl_pkg::ADDR_OFF
      |=> (q.held & ~$past(q.held)) == '0) else $error("passing while off");
   a_duty_full: assert property (e0 == 10'h3FF |=> q.pw0)
      else $error("full duty output not high");
endmodule : iosl_top

// ### shared/iosl_pkg.sv
// Constants and state type for the sampling and line-passing block.
package iosl_pkg;
   localparam int CLK_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
   localparam int PWM_PERIOD_US = 64;
   localparam int PWM_CYC = PWM_PERIOD_US * 1000 / CLK_NS;
   localparam logic [6:0] TICKS_100MS = 7'h64;
   localparam logic [21:0] DUTY_FULL = 22'h0003FF;
   localparam logic [15:0] IVL_MIN = 16'h0032;
   localparam logic [7:0] HOLD_FOREVER = 8'hFF;
   localparam logic [7:0] SPP_MIN = 8'h01;
   localparam logic [63:0] ADDR_OFF = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] ADDR_ANY = 64'h0000_0000_0000_FFFF;

   localparam logic [4:0] ID_PULL_DIR = 5'h00;
   localparam logic [4:0] ID_PULL_EN = 5'h01;
   localparam logic [4:0] ID_FWD_EN = 5'h02;
   localparam logic [4:0] ID_SPP = 5'h03;
   localparam logic [4:0] ID_OUT_LVL = 5'h04;
   localparam logic [4:0] ID_CHG_MASK = 5'h05;
   localparam logic [4:0] ID_INTERVAL = 5'h06;
   localparam logic [4:0] ID_RSSI_HOLD = 5'h07;
   localparam logic [4:0] ID_BOUND_ADDR = 5'h08;
   localparam logic [4:0] ID_LINE_HOLD0 = 5'h09;
   localparam logic [4:0] ID_LINE_HOLD7 = 5'h10;
   localparam logic [4:0] ID_PWM_HOLD = 5'h11;

   localparam logic [7:0] PULL_DIR_RST = 8'hFF;
   localparam logic [7:0] PULL_EN_RST = 8'hFF;
   localparam logic FWD_EN_RST = 1'b1;
   localparam logic [7:0] SPP_RST = 8'h01;
   localparam logic [15:0] CHG_MASK_RST = 16'h0000;
   localparam logic [15:0] INTERVAL_RST = 16'h0000;
   localparam logic [7:0] RSSI_HOLD_RST = 8'h28;
   localparam logic [7:0] LINE_HOLD_RST = 8'hFF;
   localparam logic [7:0] PWM_HOLD_RST = 8'hFF;

   localparam logic [1:0] FM_TRANSPARENT = 2'h0;
   localparam logic [1:0] PCFG_RSSI = 2'h1;
   localparam logic [1:0] PCFG_PWM = 2'h2;
   localparam logic [1:0] HK_OK = 2'h0;
   localparam logic [1:0] HK_SAMPLE = 2'h1;

   localparam logic [7:0] ASC_CR = 8'h0D;
   localparam logic [7:0] ASC_0 = 8'h30;
   localparam logic [7:0] ASC_A = 8'h41;
   localparam logic [2:0] FLD_COUNT = 3'h0;
   localparam logic [2:0] FLD_ADC0 = 3'h3;
   localparam logic [2:0] FLD_END = 3'h7;
   localparam int ADC_W = 10;

   // Pad order: line 0..4, line 6, sleep request, serial input.
   localparam int PULL_SRC [8] = '{4, 3, 2, 1, 0, 5, 6, 7};

   typedef enum logic [1:0] {ST_IDLE, ST_CHG, ST_TXT, ST_OK} iosl_st_t;
endpackage : iosl_pkg

// ### verif/iosl_host_model.sv
// Host byte sink that stalls on a fixed pattern and keeps every byte taken.
`timescale 1ns/1ps
module iosl_host_model (
   input wire logic clk_i,
   input wire logic host_valid_i,
   input wire logic [7:0] host_byte_i,
   output logic host_ready_o
);
   logic [7:0] got_q[$];
   logic [1:0] phase_q = 2'h0;
   initial host_ready_o = 1'b0;
   // Ready one cycle in four, so each byte must stand through a stall.
   always @(negedge clk_i) begin
      phase_q <= phase_q + 2'h1;
      host_ready_o <= (phase_q == 2'h3);
   end
   always @(posedge clk_i) begin
      if (host_valid_i && host_ready_o) begin
         got_q.push_back(host_byte_i);
      end
   end
endmodule : iosl_host_model

// ### verif/iosl_top_bench.sv
// Self-checking bench for the sampling and line-passing block.
`timescale 1ns/1ps
module iosl_top_bench;
   localparam int MSC = 20;
   logic clk_i, reset_i, cfg_we_i, cfg_re_i, force_sample_command_i;
   logic rx_valid_i, rx_adc0_valid_i, host_ready_i, cfg_rvalid_o;
   logic host_valid_o, host_frame_o, fwd_frame_o, sample_take_o, tx_send_o;
   logic tx_dio_only_o, first_modulated_output_o;
   logic [4:0] cfg_id_i;
   logic [63:0] cfg_wdata_i, cfg_rdata_o, rx_src_i;
   logic [1:0] frame_mode_select_i, first_modulated_config_i, host_kind_o;
   logic [1:0] second_modulated_config_i;
   logic [15:0] chan_enable_i;
   logic [7:0] max_spp_i, out_dir_i, dio_i, rx_dmask_i, rx_dio_i, host_byte_o;
   logic [7:0] tx_count_o, tx_dio_o, dio_out_o, dio_oe_o, pull_en_o, pull_up_o;
   logic [9:0] first_duty_setting_i, second_duty_setting_i, rx_adc0_i;
   logic [9:0] rx_rssi_i;
   logic [39:0] adc_i;
   logic [1:0] kinds_q[$];
   logic [8:0] tx_q[$];
   int mismatches = 0, checks_done = 0, n_fwd = 0, n_take = 0, n_pw0 = 0;
   string txt = "01/01FF/00A4/0123//";

   iosl_top #(.MS_CYCLES(MSC)) u_iosl_top (
      .clk_i, .reset_i, .cfg_we_i, .cfg_re_i, .cfg_id_i, .cfg_wdata_i,
      .cfg_rdata_o, .cfg_rvalid_o, .max_spp_i, .frame_mode_select_i,
      .chan_enable_i, .out_dir_i, .first_modulated_config_i,
      .second_modulated_config_i, .first_duty_setting_i,
      .second_duty_setting_i, .dio_i, .adc_i, .force_sample_command_i,
      .rx_valid_i, .rx_src_i, .rx_dmask_i, .rx_dio_i, .rx_adc0_valid_i,
      .rx_adc0_i, .rx_rssi_i, .host_ready_i, .host_byte_o, .host_valid_o,
      .host_frame_o, .host_kind_o, .fwd_frame_o, .sample_take_o, .tx_send_o,
      .tx_count_o, .tx_dio_only_o, .tx_dio_o, .dio_out_o, .dio_oe_o,
      .first_modulated_output_o, .second_modulated_output_o(),
      .pull_en_o, .pull_up_o);
   iosl_host_model u_iosl_host_model (.clk_i, .host_valid_i(host_valid_o),
      .host_byte_i(host_byte_o), .host_ready_o(host_ready_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (fwd_frame_o === 1'b1) n_fwd++;
      if (sample_take_o === 1'b1) n_take++;
      if (first_modulated_output_o === 1'b1) n_pw0++;
      if (host_frame_o === 1'b1) kinds_q.push_back(host_kind_o);
      if (tx_send_o === 1'b1) tx_q.push_back({tx_dio_only_o, tx_count_o});
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic wr(input logic [4:0] id, input logic [63:0] d);
      @(negedge clk_i);
      cfg_we_i = 1'b1;
      cfg_id_i = id;
      cfg_wdata_i = d;
      @(negedge clk_i);
      cfg_we_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] id, input logic [63:0] exp);
      @(negedge clk_i);
      cfg_re_i = 1'b1;
      cfg_id_i = id;
      @(negedge clk_i);
      cfg_re_i = 1'b0;
      for (int i = 0; i < 4 && cfg_rvalid_o !== 1'b1; i++) @(negedge clk_i);
      chk(cfg_rdata_o, exp);
   endtask : rd
   task automatic rx(input logic [7:0] m, input logic [7:0] v);
      @(negedge clk_i);
      rx_valid_i = 1'b1;
      rx_dmask_i = m;
      rx_dio_i = v;
      @(negedge clk_i);
      rx_valid_i = 1'b0;
   endtask : rx
   task automatic force_pulse();
      @(negedge clk_i);
      force_sample_command_i = 1'b1;
      @(negedge clk_i);
      force_sample_command_i = 1'b0;
   endtask : force_pulse
   // High cycles over one whole period must match duty d of 1023 steps.
   task automatic duty(input int d);
      n_pw0 = 0;
      cyc(iosl_pkg::PWM_CYC);
      chk(n_pw0, (d * iosl_pkg::PWM_CYC + 1022) / 1023);
   endtask : duty
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // The tests take about 10300 cycles, mostly hold and duty periods.
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      close_out();
   end

   initial begin
      {cfg_we_i, cfg_re_i, force_sample_command_i, rx_valid_i} = '0;
      {cfg_id_i, cfg_wdata_i, frame_mode_select_i, rx_dmask_i} = '0;
      {second_modulated_config_i, rx_dio_i} = '0;
      first_modulated_config_i = iosl_pkg::PCFG_PWM;
      {first_duty_setting_i, second_duty_setting_i} = {10'h200, 10'h100};
      {rx_adc0_valid_i, rx_adc0_i, rx_rssi_i} = {1'b1, 10'h155, 10'h0AA};
      {max_spp_i, chan_enable_i, out_dir_i} = {8'h0A, 16'h01FF, 8'h0F};
      {dio_i, adc_i, rx_src_i} = {8'hA5, 40'h0000000123, 64'h1234};
      reset_i = 1'b1;
      cyc(16);
      reset_i = 1'b0;
      rd(iosl_pkg::ID_PULL_DIR, 64'hFF);
      rd(iosl_pkg::ID_FWD_EN, 64'h1);
      rd(iosl_pkg::ID_SPP, 64'h1);
      rd(iosl_pkg::ID_INTERVAL, 64'h0);
      rd(iosl_pkg::ID_RSSI_HOLD, 64'h28);
      rd(iosl_pkg::ID_LINE_HOLD0, 64'hFF);
      rd(iosl_pkg::ID_PWM_HOLD, 64'hFF);
      chk(pull_up_o, 64'hFF);
      chk(pull_en_o, 64'hFF);
      duty(32'h200);
      first_duty_setting_i = 10'h3FF;
      cyc(2);
      chk(first_modulated_output_o, 1'b1);
      wr(iosl_pkg::ID_PULL_DIR, 64'h10);
      cyc(2);
      chk(pull_up_o, 64'h01);
      wr(iosl_pkg::ID_PULL_DIR, 64'h01);
      cyc(2);
      chk(pull_up_o, 64'h10);
      wr(iosl_pkg::ID_SPP, 64'h0);
      rd(iosl_pkg::ID_SPP, 64'h1);
      wr(iosl_pkg::ID_SPP, 64'hFF);
      rd(iosl_pkg::ID_SPP, 64'h0A);
      wr(iosl_pkg::ID_SPP, 64'h3);
      wr(iosl_pkg::ID_INTERVAL, 64'h5);
      rd(iosl_pkg::ID_INTERVAL, 64'h32);
      for (int i = 0; i < 1500 && n_take == 0; i++) @(negedge clk_i);
      chk(n_take, 1);
      wr(iosl_pkg::ID_CHG_MASK, 64'h1);
      dio_i = 8'hA4;
      for (int i = 0; i < 60 && tx_q.size() < 2; i++) @(negedge clk_i);
      chk(tx_q.size(), 2);
      chk(tx_q[0], 9'h001);
      chk(tx_q[1], 9'h101);
      chk(tx_dio_o, 8'hA4);
      wr(iosl_pkg::ID_INTERVAL, 64'h0);
      wr(iosl_pkg::ID_CHG_MASK, 64'h0);
      force_pulse();
      for (int i = 0; i < 400 && u_iosl_host_model.got_q.size() < 19; i++)
         @(negedge clk_i);
      chk(u_iosl_host_model.got_q.size(), 19);
      for (int i = 0; i < 19; i++) begin
         chk(u_iosl_host_model.got_q[i],
             (txt[i] == "/") ? iosl_pkg::ASC_CR : txt[i]);
      end
      frame_mode_select_i = 2'h1;
      force_pulse();
      cyc(4);
      chk(kinds_q.size(), 2);
      chk(kinds_q[0], iosl_pkg::HK_OK);
      chk(kinds_q[1], iosl_pkg::HK_SAMPLE);
      rx(8'h00, 8'h00);
      cyc(2);
      chk(n_fwd, 1);
      wr(iosl_pkg::ID_FWD_EN, 64'h0);
      rx(8'h00, 8'h00);
      cyc(2);
      chk(n_fwd, 1);
      wr(iosl_pkg::ID_OUT_LVL, 64'hFF);
      cyc(2);
      chk(dio_out_o[3:0], 4'hF);
      chk(dio_oe_o, 8'h0F);
      rx(8'h01, 8'h00);
      cyc(3);
      chk(dio_out_o[3:0], 4'hF);
      first_modulated_config_i = iosl_pkg::PCFG_RSSI;
      wr(iosl_pkg::ID_RSSI_HOLD, 64'hFF);
      wr(iosl_pkg::ID_LINE_HOLD0, 64'h1);
      wr(iosl_pkg::ID_BOUND_ADDR, iosl_pkg::ADDR_ANY);
      rx(8'h01, 8'h00);
      cyc(2);
      chk(dio_out_o[3:0], 4'hE);
      cyc(2 * 100 * MSC + 20);
      chk(dio_out_o[3:0], 4'hF);
      duty(32'h0AA);
      close_out();
   end
endmodule : iosl_top_bench
